/* logic/wmc_params.svh */
// constants for the weighing measurement chain: register map, defaults, figures
`ifndef WMC_PARAMS_SVH
`define WMC_PARAMS_SVH
`define WMC_REG_CTRL      8'h00
`define WMC_REG_LP        8'h04
`define WMC_REG_NOTCH     8'h08
`define WMC_REG_ADAPT     8'h0c
`define WMC_REG_SPAN      8'h10
`define WMC_REG_ADJ       8'h14
`define WMC_REG_G_CAL     8'h18
`define WMC_REG_G_USE     8'h1c
`define WMC_REG_INTERVAL  8'h20
`define WMC_REG_ZERO      8'h24
`define WMC_REG_TARE      8'h28
`define WMC_REG_PTARE     8'h2c
`define WMC_REG_IOCFG     8'h30
`define WMC_REG_GROSS     8'h34
`define WMC_REG_NET       8'h38
`define WMC_REG_FACTORY   8'h3c
`define WMC_REG_IOLVL     8'h40
`define WMC_REG_THEO      8'h44
`define WMC_REG_PHYS      8'h48
`define WMC_LC_COUNTS     32'h0007a120
`define WMC_HL_COUNTS     32'h000186a0
`define WMC_HL_20MA       32'h000027d8
`define WMC_LC_FS_MILLI   32'h000007d0
`define WMC_HL_FS_MILLI   32'h00002710
`define WMC_UNITY         32'h00010000
`define WMC_ADJ_MIN       32'h0000e000
`define WMC_ADJ_MAX       32'h00012000
`define WMC_G_DEFAULT     32'h0009cf5c
`define WMC_LP_CUT_RST    32'h00000004
`define WMC_ADAPT_THR_RST 32'h00000100
`define WMC_DEBOUNCE_RST  32'h00000010
`define WMC_NOTCH_SHIFT   5'h04
`define WMC_MAINS_50_LEN  4'h8
`define WMC_MAINS_60_LEN  4'h6
`endif

/* logic/wmc_pkg.sv */
// types shared by the weighing measurement chain
package wmc_pkg;
  typedef struct packed {
    logic [1:0]  htrans;
    logic [31:0] haddr;
    logic        hwrite;
    logic [2:0]  hsize;
    logic        hsel;
  } wmc_ahb_req_t;
  typedef struct packed {
    logic        valid;
    logic [31:0] data;
  } wmc_sample_t;
  typedef enum logic [1:0] {WMC_ORD2, WMC_ORD3, WMC_ORD4, WMC_ORD_BAD} wmc_order_t;
endpackage

/* logic/wmc_chain.sv */
// measurement chain of a weighing transmitter with an ahb-lite register slave
`timescale 1ns/1ns
`include "wmc_params.svh"
// Functional notes
// - load cell: 2 mV/V gives 500000 counts
// - high-level: 10 V is 100000 counts
// - one source only, fixed by configuration
// - physical calibration from one to three points
// - theoretical span from sensitivity and capacity
// - adjustment coefficient clamped to min/max
// - span scaled by use/calibration gravity ratio
// - scale interval from 1,2,5,10,20,50,100
// - rate stage rejects 50 or 60 Hz
// - low-pass order 2/3/4, adjustable cut-off
// - notch fed from low-pass or rate stage
// - adaptive stage averages within threshold, drops up to four times it, jumps beyond
// - gross includes all zero mechanisms
// - net is gross minus stored tare
// - preset tare write loads stored tare
// - factory points before user calibration
// - input/output levels readable any time
// - per-input polarity, one shared debounce
module wmc_chain #(
  parameter int HL_FITTED = 0
) (
  input  wire logic                 core_clk,    // system clock 25 MHz
  input  wire logic                 reset,       // async reset, active high
  input  wire logic                 hsel,        // slave select
  input  wire logic [31:0]          haddr,       // byte address
  input  wire logic [1:0]           htrans,      // transfer type
  input  wire logic                 hwrite,      // write strobe
  input  wire logic [2:0]           hsize,       // transfer size
  input  wire logic [31:0]          hwdata,      // write data
  input  wire logic                 hready,      // bus ready in
  output logic      [31:0]          hrdata,      // read data
  output logic                      hreadyout,   // slave ready
  output logic                      hresp,       // always okay
  input  wire wmc_pkg::wmc_sample_t adc_in,      // converter sample, signed
  input  wire logic [1:0]           in_pins,     // raw logical inputs
  input  wire logic [3:0]           out_levels,  // logical output levels
  output logic [1:0]                in_levels,   // debounced, polarity applied
  output logic [31:0]               gross_out,   // rounded gross
  output logic [31:0]               net_out      // rounded net
);
  logic                  wr_pend_r;
  logic [7:0]            wr_addr_r;
  logic [31:0] ctrl_r, lp_r, notch_r, adapt_r, span_r, adj_r, gcal_r, guse_r;
  logic [31:0] interval_r, zero_r, tare_r, iocfg_r, theo_r, phys_r;
  logic        phys_go;
  wmc_pkg::wmc_order_t ord;
  assign ord = wmc_pkg::wmc_order_t'(lp_r[1:0]);
  // full scale of the fitted source: sensitivity unit and counts at that signal
  localparam logic [63:0] FS_MILLI  = HL_FITTED != 0 ? 64'(`WMC_HL_FS_MILLI)
                                                       : 64'(`WMC_LC_FS_MILLI);
  localparam logic [63:0] FS_COUNTS = HL_FITTED != 0 ? 64'(`WMC_HL_COUNTS)
                                                       : 64'(`WMC_LC_COUNTS);
  // ctrl: [0] lp en [1] notch en [2] adaptive en [3] 60 Hz [4] zero req [5] tare req
  //       [6] tare cancel [7] theoretical cal [9] zero tracking en
  // address phase capture
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end else begin
      wr_pend_r <= hsel && hready && htrans[1] && hwrite;
      wr_addr_r <= haddr[7:0];
    end
  end
  assign phys_go = wr_pend_r && wr_addr_r == `WMC_REG_PHYS;
  logic [31:0] adj_clamped;
  always_comb begin
    adj_clamped = hwdata;
    if (hwdata < `WMC_ADJ_MIN) adj_clamped = `WMC_ADJ_MIN;
    if (hwdata > `WMC_ADJ_MAX) adj_clamped = `WMC_ADJ_MAX;
  end
  logic [31:0] ivl_legal;
  always_comb begin
    unique case (hwdata)
      32'h1, 32'h2, 32'h5, 32'ha, 32'h14, 32'h32, 32'h64: ivl_legal = hwdata;
      default: ivl_legal = interval_r;
    endcase
  end
  logic signed [31:0] gross_raw;
  logic               zero_req, tare_req, tare_cancel;
  logic [1:0]         in_edge;
  logic [1:0]         phys_cnt_r;
  logic [31:0]        ratio_acc_r, phys_span;
  logic               phys_done_r;
  logic signed [31:0] factory_r;
  // configuration registers
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ctrl_r     <= 32'h0;
      lp_r       <= `WMC_LP_CUT_RST;
      notch_r    <= 32'h0;
      adapt_r    <= `WMC_ADAPT_THR_RST;
      span_r     <= `WMC_UNITY;
      adj_r      <= `WMC_UNITY;
      gcal_r     <= `WMC_G_DEFAULT;
      guse_r     <= `WMC_G_DEFAULT;
      interval_r <= 32'h1;
      iocfg_r    <= `WMC_DEBOUNCE_RST;
      theo_r     <= 32'h0;
    end else if (wr_pend_r) begin
      unique case (wr_addr_r)
        `WMC_REG_CTRL:     ctrl_r     <= {hwdata[31:4], 4'h0} | {28'h0, hwdata[3:0]};
        `WMC_REG_LP:       lp_r       <= hwdata;
        `WMC_REG_NOTCH:    notch_r    <= hwdata;
        `WMC_REG_ADAPT:    adapt_r    <= hwdata;
        `WMC_REG_SPAN:     span_r     <= hwdata;
        `WMC_REG_ADJ:      adj_r      <= adj_clamped;
        `WMC_REG_G_CAL:    gcal_r     <= hwdata;
        `WMC_REG_G_USE:    guse_r     <= hwdata;
        `WMC_REG_INTERVAL: interval_r <= ivl_legal;
        `WMC_REG_IOCFG:    iocfg_r    <= hwdata;
        `WMC_REG_THEO:     theo_r     <= hwdata;
        default:           ;
      endcase
    end else if (ctrl_r[7]) begin
      // sensitivity [31:16] in 1/1000 mV/V, capacity [15:0] in counts
      span_r <= 32'((64'(theo_r[15:0]) * FS_MILLI * 64'(`WMC_UNITY))
                / ((64'(theo_r[31:16]) == 64'd0 ? 64'd1 : 64'(theo_r[31:16]))
                   * FS_COUNTS));
      ctrl_r[7] <= 1'b0;
    end else if (phys_done_r) begin
      span_r <= phys_span;
    end
  end
  assign zero_req    = wr_pend_r && wr_addr_r == `WMC_REG_CTRL && hwdata[4];
  assign tare_req    = (wr_pend_r && wr_addr_r == `WMC_REG_CTRL && hwdata[5]) || in_edge[0];
  assign tare_cancel = (wr_pend_r && wr_addr_r == `WMC_REG_CTRL && hwdata[6]) || in_edge[1];
  // physical calibration: up to three points, each holds reference load in counts
  // the span is taken one cycle after each accepted point unless a register write or a theoretical cal holds that cycle
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      phys_cnt_r  <= 2'h0;
      ratio_acc_r <= 32'h0;
      phys_done_r <= 1'b0;
    end else begin
      phys_done_r <= 1'b0;
      if (phys_go) begin
        if (hwdata == 32'h0) begin
          phys_cnt_r  <= 2'h0;
          ratio_acc_r <= 32'h0;
        end else if (phys_cnt_r != 2'h3) begin
          phys_cnt_r  <= phys_cnt_r + 2'h1;
          phys_done_r <= 1'b1;
          ratio_acc_r <= ratio_acc_r + 32'((64'(hwdata) * 64'(`WMC_UNITY))
                         / ((factory_r - zero_r) == 32'sh0 ? 64'd1
                            : 64'(unsigned'(factory_r - zero_r))));
        end
      end
    end
  end
  assign phys_span = phys_cnt_r == 2'h0 ? span_r : ratio_acc_r / 32'(phys_cnt_r);
  // source selection and mains rejection (moving average)
  logic signed [31:0] src;
  assign src = $signed(adc_in.data);
  logic signed [31:0] hist_r [8];
  logic signed [34:0] mains_sum;
  logic [3:0]         mains_len;
  logic signed [31:0] rate_out;
  logic               v1_r, v2_r, v3_r, v4_r, pz_done_r;
  assign mains_len = ctrl_r[3] ? `WMC_MAINS_60_LEN : `WMC_MAINS_50_LEN;
  always_comb begin
    mains_sum = '0;
    for (int i = 0; i < 8; i++)
      if (4'(i) < mains_len) mains_sum = mains_sum + 35'(hist_r[i]);
  end
  assign rate_out = 32'(ctrl_r[3] ? mains_sum / 35'sd6 : mains_sum >>> 3);
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < 8; i++) hist_r[i] <= '0;
      v1_r <= 1'b0;
    end else begin
      v1_r <= adc_in.valid;
      if (adc_in.valid) begin
        hist_r[0] <= src;
        for (int i = 1; i < 8; i++) hist_r[i] <= hist_r[i-1];
      end
    end
  end
  // low-pass: cascade of first-order sections, order selectable
  logic signed [31:0] lp_st_r [4];
  logic signed [31:0] lp_out;
  logic [4:0]         lp_k;
  assign lp_k = lp_r[20:16] == 5'h0 ? 5'h1 : lp_r[20:16];
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < 4; i++) lp_st_r[i] <= '0;
      v2_r <= 1'b0;
    end else begin
      v2_r <= v1_r;
      if (v1_r) begin
        lp_st_r[0] <= lp_st_r[0] + ((rate_out - lp_st_r[0]) >>> lp_k);
        for (int i = 1; i < 4; i++)
          lp_st_r[i] <= lp_st_r[i] + ((lp_st_r[i-1] - lp_st_r[i]) >>> lp_k);
      end
    end
  end
  always_comb begin
    unique case (ord)
      wmc_pkg::WMC_ORD2: lp_out = lp_st_r[1];
      wmc_pkg::WMC_ORD3: lp_out = lp_st_r[2];
      default:           lp_out = lp_st_r[3];
    endcase
  end
  // notch: band-stop as input minus a band-pass difference of two low-passes
  logic signed [31:0] notch_in, lo_r, hi_r, notch_out;
  assign notch_in = ctrl_r[0] ? lp_out : rate_out;
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      lo_r <= '0;
      hi_r <= '0;
      v3_r <= 1'b0;
    end else begin
      v3_r <= v2_r;
      if (v2_r) begin
        lo_r <= lo_r + ((notch_in - lo_r) >>> notch_r[4:0]);
        hi_r <= hi_r + ((notch_in - hi_r) >>> notch_r[12:8]);
      end
    end
  end
  assign notch_out = ctrl_r[1] ? notch_in - (hi_r - lo_r) : notch_in;
  // self-adaptive: average within threshold, reject up to four times it, reload beyond
  logic signed [31:0] ad_avg_r, ad_diff;
  assign ad_diff = notch_out > ad_avg_r ? notch_out - ad_avg_r : ad_avg_r - notch_out;
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ad_avg_r <= '0;
      v4_r     <= 1'b0;
    end else begin
      v4_r <= v3_r;
      if (v3_r) begin
        if (ad_diff <= $signed(adapt_r))
          ad_avg_r <= ad_avg_r + ((notch_out - ad_avg_r) >>> `WMC_NOTCH_SHIFT);
        else if (ad_diff > $signed(adapt_r << 2))
          ad_avg_r <= notch_out;
      end
    end
  end
  logic signed [31:0] filt;
  assign filt = ctrl_r[2] ? ad_avg_r : notch_out;
  // calibration, gravity correction and quantisation
  logic signed [63:0] cal_wide;
  logic signed [31:0] scaled;
  logic [31:0]        gcal_nz;
  assign gcal_nz = gcal_r == 32'h0 ? 32'h1 : gcal_r;
  // span unity is 1 count per factory point: factory units already give figures
  // signed factors keep negative loads correct through the shifts and the division
  assign cal_wide = (((64'(filt) * $signed(64'(span_r))) >>> 16)
                     * $signed(64'(adj_r))) >>> 16;
  assign scaled = 32'((cal_wide * $signed(64'(guse_r))) / $signed(64'(gcal_nz)));
  function automatic logic signed [31:0] wmc_round(input logic signed [31:0] v,
                                                   input logic [31:0] q);
    logic signed [31:0] h;
    h = $signed(q >> 1);
    wmc_round = v >= 0 ? ((v + h) / $signed(q)) * $signed(q)
                       : -(((-v) + h) / $signed(q)) * $signed(q);
  endfunction
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      factory_r <= '0;
      zero_r    <= 32'h0;
      tare_r    <= 32'h0;
      gross_out <= 32'h0;
      net_out   <= 32'h0;
      pz_done_r <= 1'b0;
    end else begin
      pz_done_r <= pz_done_r | v4_r;
      if (v4_r) factory_r <= filt;
      // power-up zero: the first sample after reset, taken once
      if (!pz_done_r && v4_r) zero_r <= scaled;
      else if (zero_req) zero_r <= scaled;
      else if (ctrl_r[9] && v4_r && gross_raw < 32'sh2 && gross_raw > -32'sh2)
        zero_r <= zero_r + gross_raw; // tracking
      if (wr_pend_r && wr_addr_r == `WMC_REG_PTARE) tare_r <= hwdata;
      else if (tare_cancel) tare_r <= 32'h0;
      else if (tare_req) tare_r <= gross_out;
      gross_out <= wmc_round(gross_raw, interval_r);
      net_out   <= wmc_round(gross_raw - $signed(tare_r), interval_r);
    end
  end
  assign gross_raw = scaled - $signed(zero_r);
  // logical inputs: polarity then shared debounce
  logic [1:0]  pol_in;
  logic [15:0] deb_cnt_r [2];
  assign pol_in = in_pins ^ iocfg_r[17:16];
  for (genvar g = 0; g < 2; g++) begin : g_in
    always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
        deb_cnt_r[g] <= 16'h0;
        in_levels[g] <= 1'b0;
        in_edge[g]   <= 1'b0;
      end else begin
        in_edge[g] <= 1'b0;
        if (pol_in[g] == in_levels[g]) deb_cnt_r[g] <= 16'h0;
        else if (deb_cnt_r[g] >= iocfg_r[15:0]) begin
          in_levels[g]  <= pol_in[g];
          in_edge[g]    <= pol_in[g];
          deb_cnt_r[g]  <= 16'h0;
        end else deb_cnt_r[g] <= deb_cnt_r[g] + 16'h1;
      end
    end
  end
  // read data and bus answer
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      hrdata    <= 32'h0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else if (hsel && hready && htrans[1] && !hwrite) begin
      unique case (haddr[7:0])
        `WMC_REG_CTRL:     hrdata <= ctrl_r;
        `WMC_REG_LP:       hrdata <= lp_r;
        `WMC_REG_NOTCH:    hrdata <= notch_r;
        `WMC_REG_ADAPT:    hrdata <= adapt_r;
        `WMC_REG_SPAN:     hrdata <= span_r;
        `WMC_REG_ADJ:      hrdata <= adj_r;
        `WMC_REG_G_CAL:    hrdata <= gcal_r;
        `WMC_REG_G_USE:    hrdata <= guse_r;
        `WMC_REG_INTERVAL: hrdata <= interval_r;
        `WMC_REG_ZERO:     hrdata <= zero_r;
        `WMC_REG_TARE:     hrdata <= tare_r;
        `WMC_REG_PTARE:    hrdata <= tare_r;
        `WMC_REG_IOCFG:    hrdata <= iocfg_r;
        `WMC_REG_GROSS:    hrdata <= gross_out;
        `WMC_REG_NET:      hrdata <= net_out;
        `WMC_REG_FACTORY:  hrdata <= factory_r;
        `WMC_REG_IOLVL:    hrdata <= {26'h0, out_levels, in_levels};
        `WMC_REG_THEO:     hrdata <= theo_r;
        `WMC_REG_PHYS:     hrdata <= {30'h0, phys_cnt_r};
        default:           hrdata <= 32'h0;
      endcase
    end
  end
  // assertions
  property p_adj_limits;
    @(posedge core_clk) disable iff (reset)
      adj_r >= `WMC_ADJ_MIN && adj_r <= `WMC_ADJ_MAX;
  endproperty
  a_adj_limits: assert property (p_adj_limits) else $error("adjust out of limits");
  property p_interval_set;
    @(posedge core_clk) disable iff (reset)
      interval_r inside {32'h1, 32'h2, 32'h5, 32'ha, 32'h14, 32'h32, 32'h64};
  endproperty
  a_interval_set: assert property (p_interval_set) else $error("illegal interval");
  property p_ptare;
    @(posedge core_clk) disable iff (reset)
      wr_pend_r && wr_addr_r == `WMC_REG_PTARE |=> tare_r == $past(hwdata);
  endproperty
  a_ptare: assert property (p_ptare) else $error("preset tare not loaded");
  property p_net;
    @(posedge core_clk) disable iff (reset)
      1'b1 |=> $signed(net_out) - ($past(gross_raw) - $signed($past(tare_r)))
                 <= $signed($past(interval_r) >> 1)
            && ($past(gross_raw) - $signed($past(tare_r))) - $signed(net_out)
                 <= $signed($past(interval_r) >> 1);
  endproperty
  a_net: assert property (p_net) else $error("net mismatch");
  property p_round;
    @(posedge core_clk) disable iff (reset)
      $signed(gross_out) % $signed(interval_r) == 0 || $changed(interval_r);
  endproperty
  a_round: assert property (p_round) else $error("gross not on interval");
  property p_bypass;
    @(posedge core_clk) disable iff (reset) ctrl_r[2:0] == 3'b000 |-> filt == rate_out;
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypassed stages altered");
  property p_notch_src;
    @(posedge core_clk) disable iff (reset) !ctrl_r[0] |-> notch_in == rate_out;
  endproperty
  a_notch_src: assert property (p_notch_src) else $error("notch source wrong");
  property p_factory;
    @(posedge core_clk) disable iff (reset) v4_r |=> factory_r == $past(filt);
  endproperty
  a_factory: assert property (p_factory) else $error("factory value stale");
  property p_debounce;
    @(posedge core_clk) disable iff (reset)
      $changed(in_levels)
        |-> ((in_levels ^ $past(in_levels)) & (in_levels ^ $past(pol_in))) == 2'b00;
  endproperty
  a_debounce: assert property (p_debounce) else $error("level not from input");
endmodule

/* verif/wmc_adc_model.sv */
// converter model that feeds factory-count samples into the chain
`timescale 1ns/1ns
module wmc_adc_model (
  input  wire logic         core_clk,  // system clock
  output wmc_pkg::wmc_sample_t sample  // one-cycle valid pulse with data
);
  initial begin
    sample = '0;
  end
  // a single source feeds the chain; samples come every fourth cycle
  task automatic send(input logic [31:0] value, input int count);
    for (int i = 0; i < count; i++) begin
      @(posedge core_clk);
      sample <= '{valid: 1'b1, data: value};
      @(posedge core_clk);
      // outside the pulse the data lines show garbage, not the held value
      sample <= '{valid: 1'b0, data: ~value};
      repeat (2) @(posedge core_clk);
    end
  endtask
endmodule

/* verif/weighing_measurement_chain_tb.sv */
// self-checking bench: register access over ahb-lite, sample path and inputs
`timescale 1ns/1ns
`include "wmc_params.svh"
`define CHK(act, exp) begin check_count++; if ((act) !== (exp)) begin bad_count++; \
  $display("ERROR t=%0t got %h expected %h", $time, (act), (exp)); end end
module weighing_measurement_chain_tb;
  logic                 core_clk;
  logic                 reset;
  logic                 hsel;
  logic [31:0]          haddr;
  logic [1:0]           htrans;
  logic                 hwrite;
  logic [2:0]           hsize;
  logic [31:0]          hwdata;
  logic [31:0]          hrdata;
  logic                 hreadyout;
  logic                 hresp;
  wmc_pkg::wmc_sample_t adc_in;
  logic [1:0]           in_pins;
  logic [3:0]           out_levels;
  logic [1:0]           in_levels;
  logic [31:0]          gross_out;
  logic [31:0]          net_out;
  logic [31:0]          rd;
  int                   bad_count;
  int                   check_count;
  logic [31:0]          ivals [7] = '{32'h1, 32'h2, 32'h5, 32'ha, 32'h14, 32'h32, 32'h64};

  wmc_chain #(.HL_FITTED(0)) dut (
    .core_clk(core_clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .adc_in(adc_in), .in_pins(in_pins),
    .out_levels(out_levels), .in_levels(in_levels), .gross_out(gross_out), .net_out(net_out)
  );
  wmc_adc_model adc (.core_clk(core_clk), .sample(adc_in));

  initial core_clk = 1'b0;
  always #20 core_clk = ~core_clk;

  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin
      bad_count++;
      $display("ERROR t=%0t got %h expected %h", $time, hreadyout, 1'b1);
    end
  endtask

  task automatic xfer(input logic [7:0] addr, input logic wr, input logic [31:0] wdata);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h000000, addr};
    hwrite <= wr;
    hsize  <= 3'b010;
    wait_ready();
    htrans <= 2'b00;
    hsel   <= 1'b0;
    hwdata <= wr ? wdata : 32'hdeadbeef;
    wait_ready();
    rd = hrdata;
    `CHK(hresp, 1'b0)
  endtask

  task automatic wr(input logic [7:0] addr, input logic [31:0] data);
    xfer(addr, 1'b1, data);
  endtask

  task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp);
    xfer(addr, 1'b0, 32'h00000000);
    `CHK(rd, exp)
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    #400000;
    bad_count++;
    conclude();
  end

  initial begin
    reset = 1'b1; hsel = 1'b0; haddr = '0; htrans = 2'b00; hwrite = 1'b0;
    hsize = 3'b010; hwdata = '0; in_pins = 2'b00; out_levels = 4'h0;
    bad_count = 0; check_count = 0; rd = '0;
    repeat (20) @(posedge core_clk);
    reset <= 1'b0;
    `CHK(hreadyout, 1'b1)
    rd_chk(`WMC_REG_G_CAL, `WMC_G_DEFAULT);
    rd_chk(`WMC_REG_G_USE, `WMC_G_DEFAULT);
    rd_chk(`WMC_REG_ADAPT, `WMC_ADAPT_THR_RST);
    rd_chk(`WMC_REG_IOCFG, `WMC_DEBOUNCE_RST);
    rd_chk(8'hfc, 32'h00000000);
    wr(`WMC_REG_ADJ, 32'h00020000);
    rd_chk(`WMC_REG_ADJ, `WMC_ADJ_MAX);
    wr(`WMC_REG_ADJ, 32'h00001000);
    rd_chk(`WMC_REG_ADJ, `WMC_ADJ_MIN);
    for (int i = 0; i < 7; i++) begin
      wr(`WMC_REG_INTERVAL, ivals[i]);
      rd_chk(`WMC_REG_INTERVAL, ivals[i]);
      wr(`WMC_REG_INTERVAL, 32'h3);
      rd_chk(`WMC_REG_INTERVAL, ivals[i]);
    end
    // unity calibration, all optional stages bypassed
    wr(`WMC_REG_CTRL, 32'h00000000);
    wr(`WMC_REG_SPAN, `WMC_UNITY);
    wr(`WMC_REG_ADJ, `WMC_UNITY);
    wr(`WMC_REG_INTERVAL, 32'h1);
    // power-up zero is taken on the first sample: present a null load first
    adc.send(32'h00000000, 1);
    adc.send(32'h000004d2, 12);
    repeat (10) @(posedge core_clk);
    rd_chk(`WMC_REG_FACTORY, 32'h000004d2);
    `CHK(gross_out, 32'h000004d2)
    rd_chk(`WMC_REG_GROSS, 32'h000004d2);
    wr(`WMC_REG_CTRL, 32'h00000008);
    adc.send(32'h000004d2, 12);
    repeat (10) @(posedge core_clk);
    `CHK(gross_out, 32'h000004d2)
    wr(`WMC_REG_CTRL, 32'h00000000);
    wr(`WMC_REG_INTERVAL, 32'ha);
    wr(`WMC_REG_PTARE, 32'h000000c8);
    adc.send(32'h000004d5, 12);
    repeat (10) @(posedge core_clk);
    `CHK(gross_out, 32'h000004d8)
    `CHK(net_out, 32'h00000410)
    rd_chk(`WMC_REG_TARE, 32'h000000c8);
    wr(`WMC_REG_CTRL, 32'h00000010);
    wr(`WMC_REG_CTRL, 32'h00000000);
    adc.send(32'h000004d5, 12);
    repeat (10) @(posedge core_clk);
    `CHK(gross_out, 32'h00000000)
    `CHK(net_out, 32'hffffff38)
    // short debounce, input 0 inverted
    wr(`WMC_REG_IOCFG, 32'h00010004);
    out_levels <= 4'ha;
    in_pins <= 2'b00;
    repeat (20) @(posedge core_clk);
    `CHK(in_levels, 2'b01)
    rd_chk(`WMC_REG_IOLVL, 32'h00000029);
    in_pins <= 2'b10;
    @(posedge core_clk);
    in_pins <= 2'b00;
    repeat (20) @(posedge core_clk);
    `CHK(in_levels, 2'b01)
    in_pins <= 2'b11;
    repeat (20) @(posedge core_clk);
    `CHK(in_levels, 2'b10)
    rd_chk(`WMC_REG_IOLVL, 32'h0000002a);
    // notch and adaptive on; zero threshold makes the average follow exactly
    wr(`WMC_REG_ADAPT, 32'h00000000);
    wr(`WMC_REG_CTRL, 32'h00000006);
    adc.send(32'h000008bd, 12);
    wr(`WMC_REG_ADAPT, `WMC_ADAPT_THR_RST);
    // outlier lifts the moving average by 0x200: between threshold and four times it
    adc.send(32'h000018bd, 1);
    adc.send(32'h000008bd, 2);
    repeat (10) @(posedge core_clk);
    `CHK(gross_out, 32'h000003e8)
    `CHK(net_out, 32'h000003e8)
    // one point: 2000 counts over 1000 factory counts above zero gives span 2.0
    wr(`WMC_REG_PHYS, 32'h000007d0);
    rd_chk(`WMC_REG_PHYS, 32'h00000001);
    rd_chk(`WMC_REG_SPAN, 32'h00020000);
    // 2.000 mV/V at 50000 capacity: 500000 counts map to 50000, span 0.1
    wr(`WMC_REG_THEO, 32'h07d0c350);
    wr(`WMC_REG_CTRL, 32'h00000080);
    repeat (2) @(posedge core_clk);
    rd_chk(`WMC_REG_SPAN, 32'h00001999);
    rd_chk(`WMC_REG_CTRL, 32'h00000000);
    conclude();
  end
endmodule
